// file: src/mode_ctl_pkg.sv
package mode_ctl_pkg;

    localparam int unsigned ADDR_W          = 4;
    localparam logic [3:0]  OFF_MODE        = 4'h0;
    localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h4;
    localparam logic [3:0]  OFF_IRQ_MASK    = 4'h8;
    localparam logic [3:0]  OFF_STACK       = 4'hc;

    localparam int unsigned BIT_SEN  = 20;
    localparam int unsigned BIT_EUN  = 17;
    localparam int unsigned BIT_XYS  = 16;
    localparam int unsigned BIT_ATE  = 15;
    localparam int unsigned BIT_APD  = 14;
    localparam int unsigned BIT_ABE  = 13;
    localparam int unsigned BIT_BRT  = 12;
    localparam int unsigned BIT_TAS  = 11;

    localparam logic [23:0] MODE_WR_MASK = 24'h11f800;
    localparam logic [23:0] MODE_RESET   = 24'h000000;
    localparam logic [15:0] SP_RESET     = 16'h0000;
    localparam logic [2:0]  STACK_ERR_LEVEL = 3'h3;

    localparam int unsigned IRQ_W         = 3;
    localparam int unsigned IRQ_UNDERFLOW = 0;
    localparam int unsigned IRQ_TA        = 1;
    localparam int unsigned IRQ_GRANT     = 2;

    localparam int unsigned SYNC_STAGES = 2;

    typedef struct packed {
        logic [15:0] addr;
        logic        req;
        logic        rel_slow;
    } ext_access_s;

    typedef struct packed {
        logic [3:0] attr_in;
        logic       attr_prio_dis;
    } attr_req_s;

endpackage

// file: src/input_sync.sv
`timescale 1ns/10ps
module input_sync
    import mode_ctl_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic raw_i,
    input  wire logic sync_en_i,
    input  wire logic assert_only_i,
    output logic      out_o
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= raw_i;
            sync_q <= meta_q;
        end
    end

    // deassert bypasses the synchroniser when only assertion is synced
    always_comb begin
        if (!sync_en_i) begin
            out_o = raw_i;
        end else if (assert_only_i) begin
            out_o = sync_q & raw_i;
        end else begin
            out_o = sync_q;
        end
    end
endmodule

// file: src/attr_prio.sv
`timescale 1ns/10ps
module attr_prio
    import mode_ctl_pkg::*;
(
    input  mode_ctl_pkg::attr_req_s req_i,
    output logic [3:0]              attr_o
);
    function automatic logic [3:0] one_hot_top(input logic [3:0] v);
        logic [3:0] r;
        r = 4'h0;
        if (v[3]) begin
            r = 4'h8;
        end else if (v[2]) begin
            r = 4'h4;
        end else if (v[1]) begin
            r = 4'h2;
        end else if (v[0]) begin
            r = 4'h1;
        end
        return r;
    endfunction

    always_comb begin
        if (req_i.attr_prio_dis) begin
            attr_o = req_i.attr_in;
        end else begin
            attr_o = one_hot_top(req_i.attr_in);
        end
    end
endmodule

// file: src/mode_reg_stack_bus_control.sv
// What this block does
// - pull with stack pointer zero in extension mode sets underflow flag.
// - underflow flag stays set until reset or a mode register write.
// - underflow flag rising raises non-maskable level 3 stack error.
// - in extension mode the pointer underflow bit counts like any bit.
// - extension maps to X space when select clear, Y when set.
// - trace enable puts internal access addresses on external address lines.
// - priority on: only highest of four attribute outputs active.
// - priority disabled: several attribute outputs may be active together.
// - async arbitration synchronises grant and busy inputs before use.
// - fast release adds no cycle, busy need not release last.
// - slow release adds one cycle, busy released after other pins.
// - with sync on, acknowledge assertion is synchronised inside.
// - extension active only while enable bit set; reset clears it.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module mode_reg_stack_bus_control
    import mode_ctl_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [ADDR_W-1:0]    adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    output logic                      err_o,
    input  wire logic                 push_i,
    input  wire logic                 pull_i,
    input  mode_ctl_pkg::ext_access_s int_access_i,
    input  wire logic [3:0]           attr_match_i,
    input  wire logic                 bus_grant_n_i,
    input  wire logic                 bus_busy_n_i,
    input  wire logic                 transfer_ack_n_i,
    output logic      [15:0]          ext_addr_o,
    output logic                      ext_addr_oe_n_o,
    output logic      [3:0]           address_attribute_outputs_o,
    output logic                      stack_space_y_o,
    output logic      [15:0]          stack_addr_o,
    output logic                      stack_error_o,
    output logic      [2:0]           stack_error_level_o,
    output logic                      access_done_o,
    output logic                      bus_busy_n_o,
    output logic                      bus_busy_oe_n_o,
    output logic                      irq_o
);
    import mode_ctl_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_EXTRA = 2'b10,
        ST_DONE  = 2'b11
    } acc_state_e;

    function automatic logic [23:0] merge_bytes(input logic [23:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [23:0] r;
        r = old_v;
        for (int i = 0; i < 3; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [23:0]      mode_q;
    logic [15:0]      sp_q;
    logic [IRQ_W-1:0] irq_status_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic             ack_q;
    logic             err_q;
    logic [31:0]      dat_q;
    logic             eun_prev_q;
    logic             stack_error_q;
    acc_state_e       acc_q;
    acc_state_e       acc_d;
    logic [15:0]      ext_addr_q;
    logic             ext_oe_n_q;
    logic             busy_n_q;
    logic             busy_oe_n_q;
    logic             done_q;
    logic [3:0]       attr_q;
    logic [3:0]       attr_d;
    logic [15:0]      stack_addr_q;
    logic             space_y_q;
    logic             grant_prev_q;
    logic             irq_q;

    logic             bus_req;
    logic             mode_wr;
    logic             ext_active;
    logic             underflow_evt;
    logic             grant_n_eff;
    logic             busy_n_eff;
    logic             ta_n_eff;
    logic             ta_asserted;
    logic             grant_rise;
    logic [IRQ_W-1:0] irq_evt;
    attr_req_s        attr_req;

    assign bus_req    = cyc_i & stb_i & ~ack_q & ~err_q;
    assign mode_wr    = bus_req & we_i & (adr_i == OFF_MODE);
    assign ext_active = mode_q[BIT_SEN];
    assign underflow_evt = pull_i & ext_active & (sp_q == 16'h0000);

    // grant and busy synchronised only in async arbitration mode
    input_sync u_grant_sync (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .raw_i         (~bus_grant_n_i),
        .sync_en_i     (mode_q[BIT_ABE]),
        .assert_only_i (1'b0),
        .out_o         (grant_n_eff)
    );

    input_sync u_busy_sync (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .raw_i         (~bus_busy_n_i),
        .sync_en_i     (mode_q[BIT_ABE]),
        .assert_only_i (1'b0),
        .out_o         (busy_n_eff)
    );

    // acknowledge: assertion synced, deassertion taken as is
    input_sync u_ta_sync (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .raw_i         (~transfer_ack_n_i),
        .sync_en_i     (mode_q[BIT_TAS]),
        .assert_only_i (1'b1),
        .out_o         (ta_n_eff)
    );

    assign ta_asserted = ta_n_eff;
    assign grant_rise  = grant_n_eff & ~grant_prev_q;

    assign attr_req.attr_in       = attr_match_i;
    assign attr_req.attr_prio_dis = mode_q[BIT_APD];

    attr_prio u_attr (
        .req_i  (attr_req),
        .attr_o (attr_d)
    );

    // mode register: software fields plus sticky underflow flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MODE_RESET;
        end else begin
            if (mode_wr) begin
                mode_q <= merge_bytes(mode_q, dat_i, sel_i) & MODE_WR_MASK;
            end
            if (underflow_evt) begin
                mode_q[BIT_EUN] <= 1'b1;
            end
        end
    end

    // stack pointer, full 16-bit counter while extension is active
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_q <= SP_RESET;
        end else if (bus_req & we_i & (adr_i == OFF_STACK)) begin
            sp_q <= dat_i[15:0];
        end else if (push_i) begin
            sp_q <= sp_q + 16'h0001;
        end else if (pull_i) begin
            if (ext_active) begin
                sp_q <= sp_q - 16'h0001;
            end else if (sp_q != 16'h0000) begin
                sp_q <= sp_q - 16'h0001;
            end
        end
    end

    // stack extension address and memory space
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stack_addr_q <= 16'h0000;
            space_y_q    <= 1'b0;
        end else begin
            stack_addr_q <= sp_q;
            space_y_q    <= mode_q[BIT_XYS];
        end
    end

    // stack error exception on 0 to 1 transition of the flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eun_prev_q    <= 1'b0;
            stack_error_q <= 1'b0;
        end else begin
            eun_prev_q    <= mode_q[BIT_EUN];
            stack_error_q <= mode_q[BIT_EUN] & ~eun_prev_q;
        end
    end

    // external access sequencer
    always_comb begin
        acc_d = acc_q;
        case (acc_q)
            ST_IDLE: begin
                if (int_access_i.req) begin
                    acc_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (ta_asserted) begin
                    acc_d = mode_q[BIT_BRT] ? ST_EXTRA : ST_DONE;
                end
            end
            ST_EXTRA: begin
                acc_d = ST_DONE;
            end
            default: begin
                acc_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q <= ST_IDLE;
        end else begin
            acc_q <= acc_d;
        end
    end

    // external pins; busy released last only in slow mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_addr_q  <= 16'h0000;
            ext_oe_n_q  <= 1'b1;
            busy_n_q    <= 1'b1;
            busy_oe_n_q <= 1'b1;
            done_q      <= 1'b0;
            attr_q      <= 4'h0;
        end else begin
            done_q <= (acc_q == ST_DONE);
            if (acc_q == ST_IDLE && int_access_i.req) begin
                ext_addr_q  <= int_access_i.addr;
                ext_oe_n_q  <= 1'b0;
                busy_n_q    <= 1'b0;
                busy_oe_n_q <= 1'b0;
                attr_q      <= attr_d;
            end else if (acc_q == ST_IDLE && mode_q[BIT_ATE]) begin
                ext_addr_q  <= int_access_i.addr;
                ext_oe_n_q  <= 1'b0;
            end else if (acc_d == ST_DONE && acc_q == ST_WAIT) begin
                ext_oe_n_q  <= 1'b1;
                attr_q      <= 4'h0;
                busy_n_q    <= 1'b1;
                busy_oe_n_q <= 1'b1;
            end else if (acc_q == ST_WAIT && acc_d == ST_EXTRA) begin
                ext_oe_n_q  <= 1'b1;
                attr_q      <= 4'h0;
            end else if (acc_q == ST_EXTRA) begin
                busy_n_q    <= 1'b1;
                busy_oe_n_q <= 1'b1;
            end else if (acc_q == ST_IDLE) begin
                ext_oe_n_q  <= 1'b1;
            end
        end
    end

    // interrupt status: set wins over write-one-to-clear
    assign irq_evt = {grant_rise, ta_asserted & (acc_q == ST_WAIT), underflow_evt};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_q <= '0;
            irq_mask_q   <= '0;
            grant_prev_q <= 1'b0;
            irq_q        <= 1'b0;
        end else begin
            grant_prev_q <= grant_n_eff;
            if (bus_req & we_i & (adr_i == OFF_IRQ_STATUS) & sel_i[0]) begin
                irq_status_q <= (irq_status_q & ~dat_i[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_status_q <= irq_status_q | irq_evt;
            end
            if (bus_req & we_i & (adr_i == OFF_IRQ_MASK) & sel_i[0]) begin
                irq_mask_q <= dat_i[IRQ_W-1:0];
            end
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // wishbone slave: one wait-free cycle answer, err on unmapped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            if (bus_req) begin
                if (adr_i == OFF_MODE) begin
                    ack_q <= 1'b1;
                    dat_q <= {8'h00, mode_q};
                end else if (adr_i == OFF_IRQ_STATUS) begin
                    ack_q <= 1'b1;
                    dat_q <= {29'h0, irq_status_q};
                end else if (adr_i == OFF_IRQ_MASK) begin
                    ack_q <= 1'b1;
                    dat_q <= {29'h0, irq_mask_q};
                end else if (adr_i == OFF_STACK) begin
                    ack_q <= 1'b1;
                    dat_q <= {13'h0, busy_n_eff, grant_n_eff, ext_active, sp_q};
                end else begin
                    err_q <= 1'b1;
                    dat_q <= 32'h0000_0000;
                end
            end
        end
    end

    assign dat_o                       = dat_q;
    assign ack_o                       = ack_q;
    assign err_o                       = err_q;
    assign ext_addr_o                  = ext_addr_q;
    assign ext_addr_oe_n_o             = ext_oe_n_q;
    assign address_attribute_outputs_o = attr_q;
    assign stack_space_y_o             = space_y_q;
    assign stack_addr_o                = stack_addr_q;
    assign stack_error_o               = stack_error_q;
    assign stack_error_level_o         = STACK_ERR_LEVEL;
    assign access_done_o               = done_q;
    assign bus_busy_n_o                = busy_n_q;
    assign bus_busy_oe_n_o             = busy_oe_n_q;
    assign irq_o                       = irq_q;

    chk_underflow_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        underflow_evt |=> mode_q[BIT_EUN]) else $error("underflow flag not set");
    chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_q[BIT_EUN] && !mode_wr) |=> mode_q[BIT_EUN]) else $error("flag lost");
    chk_stack_error: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(mode_q[BIT_EUN])) |=> stack_error_o) else $error("no stack error");
    chk_space_select: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> stack_space_y_o == $past(mode_q[BIT_XYS])) else $error("space wrong");
    chk_attr_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
        !mode_q[BIT_APD] |-> $onehot0(attr_d)) else $error("attr not one-hot");
    chk_attr_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q[BIT_APD] |-> attr_d == attr_match_i) else $error("attr altered");
    chk_slow_extra: assert property (@(posedge clk_i) disable iff (rst_i)
        (acc_q == ST_WAIT && ta_asserted && mode_q[BIT_BRT]) |=> acc_q == ST_EXTRA ##1 acc_q == ST_DONE)
        else $error("slow release missing cycle");
    chk_fast_release: assert property (@(posedge clk_i) disable iff (rst_i)
        (acc_q == ST_WAIT && ta_asserted && !mode_q[BIT_BRT]) |=> acc_q == ST_DONE && bus_busy_oe_n_o)
        else $error("fast release wrong");
    chk_wrap_counter: assert property (@(posedge clk_i) disable iff (rst_i)
        (pull_i && !push_i && ext_active && sp_q == 16'h0000 && !(bus_req && we_i && adr_i == OFF_STACK))
        |=> sp_q == 16'hffff) else $error("pointer did not wrap");
endmodule

// file: verif/ext_bus_model.sv
`timescale 1ns/10ps
module ext_bus_model (
    input  wire logic       clk_i,
    input  wire logic       busy_drv_n_i,
    input  wire logic       busy_oe_n_i,
    input  wire logic       grant_i,
    input  wire logic [3:0] wait_i,
    output logic            ack_n_o,
    output logic            grant_n_o,
    output logic            busy_n_o
);
    logic [3:0] cnt_q = 4'h0;
    logic [1:0] gap_q = 2'h0;
    logic       done_q = 1'b0;
    initial ack_n_o = 1'b1;
    initial grant_n_o = 1'b1;
    // busy line pulled up when the device lets go, nobody else drives it
    assign busy_n_o = busy_oe_n_i ? 1'b1 : busy_drv_n_i;
    // acknowledge after wait_i cycles of a busy access, held until busy released
    always @(posedge clk_i) begin
        if (busy_n_o) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
            ack_n_o <= 1'b1;
        end else if (!done_q && cnt_q == wait_i) begin
            done_q <= 1'b1;
            ack_n_o <= 1'b0;
        end else if (!done_q) begin
            cnt_q <= cnt_q + 4'h1;
            ack_n_o <= 1'b1;
        end
    end
    // grant only after three idle cycles
    always @(posedge clk_i) begin
        if (!grant_n_o) begin
            gap_q <= 2'h0;
        end else if (gap_q != 2'h3) begin
            gap_q <= gap_q + 2'h1;
        end
        grant_n_o <= !(grant_i && (!grant_n_o || gap_q == 2'h3));
    end
endmodule

// file: verif/mode_reg_stack_bus_control_bench.sv
`timescale 1ns/10ps
module mode_reg_stack_bus_control_bench;
    import mode_ctl_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'hf, attr_match_i = 4'h0, wait_q = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic        push_i = 1'b0, pull_i = 1'b0, grant_q = 1'b0;
    ext_access_s int_access_i = '0;
    logic        ack_o, err_o, bus_grant_n_i, bus_busy_n_i, transfer_ack_n_i, ext_addr_oe_n_o;
    logic        stack_space_y_o, stack_error_o, access_done_o, bus_busy_n_o, bus_busy_oe_n_o, irq_o;
    logic [15:0] ext_addr_o, stack_addr_o;
    logic [3:0]  address_attribute_outputs_o;
    logic [2:0]  stack_error_level_o;
    int          bad_count = 0;
    int          checks_done = 0;
    int          err_pulses = 0;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (stack_error_o === 1'b1) err_pulses <= err_pulses + 1;
    mode_reg_stack_bus_control dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .err_o, .push_i, .pull_i, .int_access_i, .attr_match_i, .bus_grant_n_i,
        .bus_busy_n_i, .transfer_ack_n_i, .ext_addr_o, .ext_addr_oe_n_o, .address_attribute_outputs_o,
        .stack_space_y_o, .stack_addr_o, .stack_error_o, .stack_error_level_o, .access_done_o,
        .bus_busy_n_o, .bus_busy_oe_n_o, .irq_o);
    ext_bus_model far_u (.clk_i(clk_i), .busy_drv_n_i(bus_busy_n_o), .busy_oe_n_i(bus_busy_oe_n_o),
        .grant_i(grant_q), .wait_i(wait_q), .ack_n_o(transfer_ack_n_i), .grant_n_o(bus_grant_n_i),
        .busy_n_o(bus_busy_n_i));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        r = dat_o;
        e = err_o;
        if (n >= 20) bad_count++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        bus(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        bus(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask
    task automatic pull_once();
        @(posedge clk_i);
        pull_i <= 1'b1;
        @(posedge clk_i);
        pull_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [3:0] top1(input logic [3:0] v);
        return v[3] ? 4'h8 : v[2] ? 4'h4 : v[1] ? 4'h2 : v[0] ? 4'h1 : 4'h0;
    endfunction
    // access: cycles to done, and busy release minus address release
    task automatic xfer(input logic [31:0] mode, input logic [3:0] w, output int d, output int g);
        int a, b, s;
        wr(OFF_MODE, mode);
        wait_q <= w;
        a = 0;
        b = 0;
        s = 0;
        d = 0;
        @(posedge clk_i);
        int_access_i.req <= 1'b1;
        @(posedge clk_i);
        int_access_i.req <= 1'b0;
        for (int n = 1; n < 40 && (d == 0 || b == 0); n++) begin
            @(posedge clk_i);
            if (ext_addr_oe_n_o === 1'b0) s = 1;
            if (s == 1 && a == 0 && ext_addr_oe_n_o === 1'b1) a = n;
            if (s == 1 && b == 0 && bus_busy_oe_n_o === 1'b1) b = n;
            if (d == 0 && access_done_o === 1'b1) d = n;
        end
        g = b - a;
    endtask
    task automatic grant_lat(input logic [31:0] mode, output int l);
        wr(OFF_MODE, mode);
        grant_q <= 1'b0;
        repeat (8) @(posedge clk_i);
        wr(OFF_IRQ_STATUS, 32'h4);
        grant_q <= 1'b1;
        repeat (2) @(posedge clk_i);
        l = 0;
        while (irq_o !== 1'b1 && l < 30) begin
            @(posedge clk_i);
            l++;
        end
    endtask
    initial begin
        #50000;
        bad_count++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic        e;
        int          d0, d3, ds, dt, g, l0, la;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFF_MODE, 32'h0);
        rd(OFF_STACK, 32'h0);
        chk(stack_error_level_o, STACK_ERR_LEVEL);
        bus(1'b1, 4'h2, 32'hffffffff, r, e);
        chk(e, 1'b1);
        wr(OFF_MODE, 32'hfffdffff);
        rd(OFF_MODE, MODE_WR_MASK);
        $display("test reset_map done");
        wr(OFF_MODE, 32'h0);
        wr(OFF_STACK, 32'h0);
        pull_once();
        rd(OFF_STACK, 32'h0);
        chk(err_pulses, 0);
        wr(OFF_MODE, 32'h100000);
        pull_once();
        chk(err_pulses, 1);
        rd(OFF_MODE, 32'h120000);
        rd(OFF_STACK, 32'h1ffff);
        pull_once();
        chk(err_pulses, 1);
        rd(OFF_MODE, 32'h120000);
        wr(OFF_MODE, 32'h110000);
        rd(OFF_MODE, 32'h110000);
        chk(stack_space_y_o, 1'b1);
        wr(OFF_MODE, 32'h100000);
        repeat (2) @(posedge clk_i);
        chk(stack_space_y_o, 1'b0);
        $display("test underflow done");
        for (int p = 0; p < 2; p++) begin
            wr(OFF_MODE, p ? 32'h4000 : 32'h0);
            for (int v = 0; v < 16; v++) begin
                attr_match_i <= v[3:0];
                int_access_i.req <= 1'b1;
                @(posedge clk_i);
                int_access_i.req <= 1'b0;
                @(posedge clk_i);
                chk(address_attribute_outputs_o, p ? v[3:0] : top1(v[3:0]));
                repeat (4) @(posedge clk_i);
            end
        end
        wr(OFF_MODE, 32'h8000);
        int_access_i.addr <= 16'h1234;
        repeat (3) @(posedge clk_i);
        chk({ext_addr_oe_n_o, ext_addr_o}, {1'b0, 16'h1234});
        wr(OFF_MODE, 32'h0);
        repeat (3) @(posedge clk_i);
        chk(ext_addr_oe_n_o, 1'b1);
        $display("test attr_trace done");
        wr(OFF_IRQ_MASK, 32'h4);
        grant_lat(32'h0, l0);
        chk(irq_o, 1'b1);
        grant_lat(32'h2000, la);
        chk(la - l0, SYNC_STAGES);
        rd(OFF_STACK, 32'h2fffe);
        wr(OFF_IRQ_STATUS, 32'h7);
        rd(OFF_IRQ_STATUS, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        $display("test arbitration done");
        xfer(32'h0, 4'h0, d0, g);
        chk(g, 0);
        xfer(32'h0, 4'h3, d3, g);
        chk(d3 - d0, 3);
        xfer(32'h1000, 4'h0, ds, g);
        chk(g, 1);
        chk(ds - d0, 1);
        xfer(32'h800, 4'h0, dt, g);
        chk(dt - d0, SYNC_STAGES);
        $display("test access done");
        close_out();
    end
endmodule
